// [design/dcm_al_delay.sv]
// additive latency delay line for column commands
`timescale 1ns/1ps
`default_nettype none
module dcm_al_delay #(
    parameter int DEPTH = 7
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [2:0] latency,
    input wire logic inValid,
    input wire dcm_pkg::dcm_colcmd_t inCmd,
    output logic outValid,
    output dcm_pkg::dcm_colcmd_t outCmd
);
    logic [DEPTH-1:0] vld_r;
    dcm_pkg::dcm_colcmd_t cmd_r [DEPTH];
    logic [2:0] tap;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vld_r <= '0;
        end else begin
            vld_r <= {vld_r[DEPTH-2:0], inValid};
        end
    end

    always_ff @(posedge clk_sys) begin
        cmd_r[0] <= inCmd;
        for (int k = 1; k < DEPTH; k++) begin
            cmd_r[k] <= cmd_r[k-1];
        end
    end

    always_comb begin
        tap = (latency > 3'(DEPTH)) ? 3'(DEPTH - 1) : latency - 3'h1;
        if (latency == 3'h0) begin
            outValid = inValid;
            outCmd = inCmd;
        end else begin
            outValid = vld_r[tap];
            outCmd = cmd_r[tap];
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    al_two_a: assert property (latency == 3'h2 && inValid ##1 latency == 3'h2 |=> outValid)
        else $error("column command not delayed by additive latency");
    al_zero_a: assert property (latency == 3'h0 |-> outValid == inValid)
        else $error("zero latency must pass through");
endmodule // dcm_al_delay
`default_nettype wire

// [design/dcm_burst_gen.sv]
// burst column order generator
`timescale 1ns/1ps
`default_nettype none
`include "dcm_params.svh"
module dcm_burst_gen (
    input wire logic clk_sys,
    input wire logic rst_n,
    dcm_burst_if.gen bif
);
    logic active_r;
    logic bl8_r;
    logic ilv_r;
    logic [2:0] cnt_r;
    logic [2:0] start_r;

    function automatic logic [2:0] burstCol(input logic [2:0] st, input logic [2:0] c,
                                            input logic b8, input logic il);
        logic [2:0] low;
        low = 3'h0;
        if (il) begin
            low = st ^ c;
            if (!b8) begin
                low[2] = st[2];
            end
        end else begin
            low[1:0] = st[1:0] + c[1:0];
            low[2] = b8 ? (st[2] ^ c[2]) : st[2];
        end
        return low;
    endfunction

    // ----------------------------------------
    // burst counter
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            cnt_r <= 3'h0;
            start_r <= 3'h0;
            bl8_r <= 1'b0;
            ilv_r <= 1'b0;
        end else if (bif.start) begin
            active_r <= 1'b1;
            cnt_r <= 3'h0;
            start_r <= bif.startCol;
            bl8_r <= bif.bl8;
            ilv_r <= bif.ilv;
        end else if (active_r) begin
            active_r <= !bif.last;
            cnt_r <= cnt_r + 3'h1;
        end
    end

    assign bif.active = active_r;
    assign bif.count = cnt_r;
    assign bif.last = active_r && (cnt_r == (bl8_r ? `DCM_BL8_LAST : `DCM_BL4_LAST));
    assign bif.colLow = burstCol(start_r, cnt_r, bl8_r, ilv_r);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    len_eight_a: assert property (bif.start && bif.bl8 |=> active_r [*8] ##1 !active_r)
        else $error("eight long burst has wrong length");
    len_four_a: assert property (bif.start && !bif.bl8 |=> active_r [*4] ##1 !active_r)
        else $error("four long burst has wrong length");
    ilv_order_a: assert property (active_r && ilv_r && bl8_r |-> bif.colLow == (start_r ^ cnt_r))
        else $error("interleaved order wrong");
    seq_half_a: assert property (active_r && !ilv_r && bl8_r |-> bif.colLow[2] == (start_r[2] ^ cnt_r[2]))
        else $error("nibble select wrong in second half");
    seq_four_a: assert property (active_r && !bl8_r |-> bif.colLow[2] == start_r[2])
        else $error("four long burst left its block");
endmodule // dcm_burst_gen
`default_nettype wire

// [design/dcm_burst_if.sv]
// link between command control and burst address generator
`timescale 1ns/1ps
`default_nettype none
interface dcm_burst_if;
    logic start;
    logic bl8;
    logic ilv;
    logic [2:0] startCol;
    logic active;
    logic last;
    logic [2:0] count;
    logic [2:0] colLow;

    modport ctrl (output start, output bl8, output ilv, output startCol,
                  input active, input last, input count, input colLow);
    modport gen (input start, input bl8, input ilv, input startCol,
                 output active, output last, output count, output colLow);
endinterface
`default_nettype wire

// [design/dcm_cmd_ctrl.sv]
// command decode, bank row state, mode registers and bursts
`timescale 1ns/1ps
`default_nettype none
`include "dcm_params.svh"
module dcm_cmd_ctrl #(
    parameter int PRE_CYCLES = `DCM_PRECHARGE_CYC,
    parameter int AL_DEPTH = 7,
    parameter int DQ_W = `DCM_DQ_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [1:0] ba,
    input wire logic [`DCM_ADDR_W-1:0] addr,
    input wire logic dataMask,
    input wire logic [DQ_W-1:0] dqIn,
    output logic [`DCM_MODE_W-1:0] modeReg_r,
    output logic [`DCM_MODE_W-1:0] extModeReg_r,
    output logic [3:0] bankOpen_r,
    output logic [3:0] bankPrecharging_r,
    output logic memRdEn_r,
    output logic memWrEn_r,
    output logic [1:0] memBank_r,
    output logic [`DCM_ADDR_W-1:0] memRow_r,
    output logic [`DCM_COL_W-1:0] memCol_r,
    output logic [DQ_W-1:0] memWrData_r,
    output logic refreshStb_r,
    output logic [`DCM_ADDR_W-1:0] refreshRow_r,
    output logic selfRefresh_r,
    output logic dllOn_r,
    output logic dllReset_r
);
    dcm_burst_if bif ();

    logic ckePrev_r;
    logic cmdTaken;
    dcm_pkg::dcm_cmd_t cmd;
    logic colValid;
    dcm_pkg::dcm_colcmd_t colIn;
    logic colFire;
    dcm_pkg::dcm_colcmd_t colCmd;
    logic [2:0] alSetting;
    dcm_pkg::dcm_burst_st_t burstSt_r;
    logic [1:0] burstBank_r;
    logic [`DCM_COL_W-4:0] burstColHi_r;
    logic burstAp_r;
    logic apFire;
    logic srEnter;
    logic [`DCM_ADDR_W-1:0] rowAddr_r [4];
    logic [7:0] preCnt_r [4];

    function automatic dcm_pkg::dcm_cmd_t decodeCmd(input logic r, input logic c, input logic w);
        dcm_pkg::dcm_cmd_t d;
        d = dcm_pkg::DCM_CMD_NOP;
        unique case ({r, c, w})
            3'h3: d = dcm_pkg::DCM_CMD_ACT;
            3'h5: d = dcm_pkg::DCM_CMD_READ;
            3'h4: d = dcm_pkg::DCM_CMD_WRITE;
            3'h2: d = dcm_pkg::DCM_CMD_PRE;
            3'h1: d = dcm_pkg::DCM_CMD_REF;
            3'h0: d = dcm_pkg::DCM_CMD_LOAD;
            3'h7, 3'h6: d = dcm_pkg::DCM_CMD_NOP;
        endcase
        return d;
    endfunction

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    assign cmdTaken = !csN && cke && ckePrev_r && !selfRefresh_r;
    assign cmd = cmdTaken ? decodeCmd(rasN, casN, weN) : dcm_pkg::DCM_CMD_NOP;
    assign srEnter = !csN && ckePrev_r && !cke && !selfRefresh_r
                     && decodeCmd(rasN, casN, weN) == dcm_pkg::DCM_CMD_REF;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ckePrev_r <= 1'b0;
        end else begin
            ckePrev_r <= cke;
        end
    end

    // ----------------------------------------
    // mode registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            modeReg_r <= `DCM_MR_RESET;
            extModeReg_r <= `DCM_MR_RESET;
        end else if (cmd == dcm_pkg::DCM_CMD_LOAD && ba == `DCM_BA_MODE) begin
            modeReg_r <= addr[`DCM_MODE_W-1:0];
        end else if (cmd == dcm_pkg::DCM_CMD_LOAD && ba == `DCM_BA_EXT) begin
            extModeReg_r <= addr[`DCM_MODE_W-1:0];
        end else begin
            modeReg_r[`DCM_MR_DLLRST_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------
    // self refresh and delay loop
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            selfRefresh_r <= 1'b0;
            dllOn_r <= 1'b1;
            dllReset_r <= 1'b0;
        end else begin
            dllReset_r <= modeReg_r[`DCM_MR_DLLRST_BIT] || (selfRefresh_r && cke);
            if (srEnter) begin
                selfRefresh_r <= 1'b1;
                dllOn_r <= 1'b0;
            end else if (selfRefresh_r && cke) begin
                selfRefresh_r <= 1'b0;
                dllOn_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // refresh row counter
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refreshStb_r <= 1'b0;
            refreshRow_r <= '0;
        end else begin
            refreshStb_r <= (cmd == dcm_pkg::DCM_CMD_REF) || srEnter;
            if (cmd == dcm_pkg::DCM_CMD_REF || srEnter) begin
                refreshRow_r <= refreshRow_r + `DCM_ADDR_W'(1);
            end
        end
    end

    // ----------------------------------------
    // bank row state
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bankOpen_r <= 4'h0;
            bankPrecharging_r <= 4'h0;
            for (int b = 0; b < 4; b++) begin
                rowAddr_r[b] <= '0;
                preCnt_r[b] <= 8'h00;
            end
        end else begin
            for (int b = 0; b < 4; b++) begin
                bankPrecharging_r[b] <= preCnt_r[b] > 8'h01;
                if (preCnt_r[b] != 8'h00) begin
                    preCnt_r[b] <= preCnt_r[b] - 8'h01;
                end
                if (apFire && burstBank_r == 2'(b)) begin
                    bankOpen_r[b] <= 1'b0;
                    preCnt_r[b] <= 8'(PRE_CYCLES);
                    bankPrecharging_r[b] <= 1'b1;
                end
                if (cmd == dcm_pkg::DCM_CMD_PRE && (addr[`DCM_AP_BIT] || ba == 2'(b))) begin
                    bankOpen_r[b] <= 1'b0;
                    preCnt_r[b] <= 8'(PRE_CYCLES);
                    bankPrecharging_r[b] <= 1'b1;
                end
                if (cmd == dcm_pkg::DCM_CMD_ACT && ba == 2'(b)) begin
                    bankOpen_r[b] <= 1'b1;
                    rowAddr_r[b] <= addr;
                end
            end
        end
    end

    // ----------------------------------------
    // column commands through additive latency
    // ----------------------------------------
    assign alSetting = extModeReg_r[`DCM_EMR_AL_MSB:`DCM_EMR_AL_LSB];
    assign colValid = cmd == dcm_pkg::DCM_CMD_READ || cmd == dcm_pkg::DCM_CMD_WRITE;
    assign colIn = '{wr: cmd == dcm_pkg::DCM_CMD_WRITE, ap: addr[`DCM_AP_BIT],
                     bank: ba, col: addr[`DCM_COL_W-1:0]};

    dcm_al_delay #(
        .DEPTH(AL_DEPTH)
    ) u_al (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .latency(alSetting),
        .inValid(colValid),
        .inCmd(colIn),
        .outValid(colFire),
        .outCmd(colCmd)
    );

    // ----------------------------------------
    // burst control
    // ----------------------------------------
    assign bif.start = colFire;
    assign bif.startCol = colCmd.col[2:0];
    assign bif.bl8 = modeReg_r[`DCM_MR_BL_MSB:`DCM_MR_BL_LSB] == `DCM_BL8_CODE;
    assign bif.ilv = modeReg_r[`DCM_MR_BT_BIT];
    assign apFire = bif.last && burstAp_r && !colFire;

    dcm_burst_gen u_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bif(bif)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            burstSt_r <= dcm_pkg::DCM_BS_IDLE;
            burstBank_r <= 2'h0;
            burstColHi_r <= '0;
            burstAp_r <= 1'b0;
        end else if (colFire) begin
            burstSt_r <= colCmd.wr ? dcm_pkg::DCM_BS_WRITE : dcm_pkg::DCM_BS_READ;
            burstBank_r <= colCmd.bank;
            burstColHi_r <= colCmd.col[`DCM_COL_W-1:3];
            burstAp_r <= colCmd.ap;
        end else begin
            unique case (burstSt_r)
                dcm_pkg::DCM_BS_IDLE: burstAp_r <= 1'b0;
                dcm_pkg::DCM_BS_READ, dcm_pkg::DCM_BS_WRITE: begin
                    if (bif.last) begin
                        burstSt_r <= dcm_pkg::DCM_BS_IDLE;
                    end
                end
                default: burstSt_r <= dcm_pkg::DCM_BS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // array access strobes
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            memRdEn_r <= 1'b0;
            memWrEn_r <= 1'b0;
            memBank_r <= 2'h0;
            memRow_r <= '0;
            memCol_r <= '0;
            memWrData_r <= '0;
        end else begin
            memRdEn_r <= bif.active && burstSt_r == dcm_pkg::DCM_BS_READ;
            memWrEn_r <= bif.active && burstSt_r == dcm_pkg::DCM_BS_WRITE && !dataMask;
            memBank_r <= burstBank_r;
            memRow_r <= rowAddr_r[burstBank_r];
            memCol_r <= {burstColHi_r, bif.colLow};
            memWrData_r <= dqIn;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    nop_hold_a: assert property (cmd == dcm_pkg::DCM_CMD_NOP && !apFire |=> $stable(bankOpen_r))
        else $error("bank state changed on no operation");
    desel_ignore_a: assert property (csN && !apFire |=> $stable(bankOpen_r) && $stable(modeReg_r[7:0]))
        else $error("deselected command took effect");
    mode_load_a: assert property (cmd == dcm_pkg::DCM_CMD_LOAD && ba == `DCM_BA_MODE
                                  |=> modeReg_r[7:0] == $past(addr[7:0]))
        else $error("mode register not loaded from address");
    dll_clear_a: assert property (modeReg_r[`DCM_MR_DLLRST_BIT] && cmd != dcm_pkg::DCM_CMD_LOAD
                                  |=> !modeReg_r[`DCM_MR_DLLRST_BIT] && dllReset_r)
        else $error("dll reset bit did not clear itself");
    act_open_a: assert property (cmd == dcm_pkg::DCM_CMD_ACT ##1 cmd == dcm_pkg::DCM_CMD_NOP
                                 |-> bankOpen_r[$past(ba)] && rowAddr_r[$past(ba)] == $past(addr))
        else $error("activate did not open row");
    pre_all_a: assert property (cmd == dcm_pkg::DCM_CMD_PRE && addr[`DCM_AP_BIT]
                                |=> bankOpen_r == 4'h0 && bankPrecharging_r == 4'hF)
        else $error("precharge all left a bank open");
    pre_restart_a: assert property (cmd == dcm_pkg::DCM_CMD_PRE |=> preCnt_r[$past(ba)] == 8'(PRE_CYCLES))
        else $error("precharge period not restarted");
    ap_close_a: assert property (apFire |=> !bankOpen_r[$past(burstBank_r)])
        else $error("auto precharge did not close row");
    wr_mask_a: assert property (bif.active && dataMask |=> !memWrEn_r)
        else $error("masked data was stored");
    ref_count_a: assert property (cmd == dcm_pkg::DCM_CMD_REF |=> refreshRow_r == $past(refreshRow_r) + 14'h0001)
        else $error("refresh row counter did not advance");
    sref_dll_a: assert property (srEnter |=> selfRefresh_r && !dllOn_r)
        else $error("self refresh did not stop the delay loop");
    sref_exit_a: assert property (selfRefresh_r && cke |=> !selfRefresh_r && dllOn_r && dllReset_r)
        else $error("delay loop not restarted on exit");

    rd_burst_c: cover property (colFire && !colCmd.wr ##1 bif.active [*8]);
    wr_ap_c: cover property (apFire && burstSt_r == dcm_pkg::DCM_BS_WRITE);
    sref_c: cover property (srEnter ##[1:20] selfRefresh_r && cke);
    bl8_end_c: cover property (bif.last && bif.count == 3'h7);
endmodule // dcm_cmd_ctrl
`default_nettype wire

// [design/dcm_params.svh]
// constants of the command and mode logic
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH

// ----------------------------------------
// pin widths
// ----------------------------------------
`define DCM_ADDR_W 14
`define DCM_COL_W 10
`define DCM_MODE_W 13
`define DCM_DQ_W 8

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define DCM_MR_BL_LSB 0
`define DCM_MR_BL_MSB 2
`define DCM_MR_BT_BIT 3
`define DCM_MR_DLLRST_BIT 8
`define DCM_BL4_CODE 3'h2
`define DCM_BL8_CODE 3'h3
`define DCM_EMR_AL_LSB 3
`define DCM_EMR_AL_MSB 5
`define DCM_MR_RESET 13'h0000
`define DCM_AP_BIT 10
`define DCM_BA_MODE 2'h0
`define DCM_BA_EXT 2'h1
`define DCM_BL4_LAST 3'h3
`define DCM_BL8_LAST 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define DCM_CLK_PERIOD_NS 40
`define DCM_PRECHARGE_PERIOD_NS 15
`define DCM_PRECHARGE_CYC \
    ((`DCM_PRECHARGE_PERIOD_NS + `DCM_CLK_PERIOD_NS - 1) / `DCM_CLK_PERIOD_NS)

`endif

// [design/dcm_pkg.sv]
// types of the command and mode logic
package dcm_pkg;
    typedef enum logic [2:0] {
        DCM_CMD_NOP, DCM_CMD_ACT, DCM_CMD_READ, DCM_CMD_WRITE,
        DCM_CMD_PRE, DCM_CMD_REF, DCM_CMD_LOAD
    } dcm_cmd_t;

    typedef enum logic [1:0] {DCM_BS_IDLE, DCM_BS_READ, DCM_BS_WRITE} dcm_burst_st_t;

    typedef struct packed {
        logic wr;
        logic ap;
        logic [1:0] bank;
        logic [9:0] col;
    } dcm_colcmd_t;
endpackage

// [testbench/dcm_ctl_model.sv]
// controller model driving command, address, mask and data pins
`timescale 1ns/1ps
`default_nettype none
module dcm_ctl_model (
    input wire logic clk_sys,
    output logic cke,
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [1:0] ba,
    output logic [13:0] addr,
    output logic dataMask,
    output logic [7:0] dqIn
);
    int seed = 32'h36d9f0ea;
    initial begin
        cke = 1'b1;
        csN = 1'b1;
        {rasN, casN, weN} = 3'h7;
        ba = 2'h0;
        addr = 14'h0000;
        dataMask = 1'b0;
        dqIn = 8'h00;
    end
    always @(posedge clk_sys) dqIn <= 8'($random(seed));
    // one command cycle, then nop with released address lines inverted
    task automatic issue(input logic [2:0] code, input logic [1:0] b, input logic [13:0] a,
                         input logic sel, input logic ck, input logic msk);
        @(posedge clk_sys);
        cke <= ck;
        csN <= ~sel;
        {rasN, casN, weN} <= code;
        ba <= b;
        addr <= a;
        dataMask <= msk;
        @(posedge clk_sys);
        csN <= 1'b0;
        {rasN, casN, weN} <= 3'h7;
        ba <= ~b;
        addr <= ~a;
    endtask
endmodule // dcm_ctl_model
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench of the command and mode logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    wire logic cke, csN, rasN, casN, weN, dataMask;
    wire logic [1:0] ba;
    wire logic [13:0] addr;
    wire logic [7:0] dqIn;
    logic [12:0] modeReg_r, extModeReg_r;
    logic [3:0] bankOpen_r, bankPrecharging_r;
    logic memRdEn_r, memWrEn_r, refreshStb_r, selfRefresh_r, dllOn_r, dllReset_r;
    logic [1:0] memBank_r;
    logic [13:0] memRow_r, refreshRow_r;
    logic [9:0] memCol_r;
    logic [7:0] memWrData_r;
    logic [13:0] rowOf [4];
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'h36d9f0ea;
    always #20 clk_sys = ~clk_sys;
    dcm_ctl_model ctl_u (.clk_sys(clk_sys), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
        .ba(ba), .addr(addr), .dataMask(dataMask), .dqIn(dqIn));
    dcm_cmd_ctrl #(.PRE_CYCLES(6)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cke(cke), .csN(csN),
        .rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr), .dataMask(dataMask), .dqIn(dqIn),
        .modeReg_r(modeReg_r), .extModeReg_r(extModeReg_r), .bankOpen_r(bankOpen_r),
        .bankPrecharging_r(bankPrecharging_r), .memRdEn_r(memRdEn_r), .memWrEn_r(memWrEn_r),
        .memBank_r(memBank_r), .memRow_r(memRow_r), .memCol_r(memCol_r), .memWrData_r(memWrData_r),
        .refreshStb_r(refreshStb_r), .refreshRow_r(refreshRow_r), .selfRefresh_r(selfRefresh_r),
        .dllOn_r(dllOn_r), .dllReset_r(dllReset_r));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            complete_run();
        end
    end
    function automatic logic [9:0] expCol(logic [9:0] s, logic [2:0] k, logic bl8, logic ilv);
        logic [2:0] lo;
        lo = ilv ? (s[2:0] ^ k) : {s[2] ^ (bl8 & k[2]), s[1:0] + k[1:0]};
        return {s[9:3], lo};
    endfunction
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic burst(input logic wr, input logic ap, input logic msk, input logic [1:0] b,
                         input logic [9:0] col, input logic bl8, input logic ilv, output int first, output int beats);
        logic [7:0] d;
        first = -1;
        beats = 0;
        ctl_u.issue(wr ? 3'h4 : 3'h5, b, {3'h0, ap, col}, 1'b1, 1'b1, msk);
        for (int i = 1; i < 24; i++) begin
            #1;
            d = dqIn;
            @(posedge clk_sys);
            #1;
            if (memWrEn_r) check("data", memWrData_r, d);
            if (memRdEn_r | memWrEn_r) begin
                if (first < 0) first = i;
                check("col", memCol_r, expCol(col, beats[2:0], bl8, ilv));
                check("bank", memBank_r, b);
                check("row", memRow_r, rowOf[b]);
                beats++;
            end
        end
    endtask
    task automatic open(input logic [1:0] b);
        rowOf[b] = 14'($random(seed));
        ctl_u.issue(3'h3, b, rowOf[b], 1'b1, 1'b1, 1'b0);
        settle();
        check("open", bankOpen_r[b], 1);
    endtask
    initial begin
        int f0, f2, n;
        logic [9:0] c;
        logic [13:0] r;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check("dllOn", dllOn_r, 1);
        check("rstMode", modeReg_r, 0);
        for (int m = 0; m < 4; m++) begin
            ctl_u.issue(3'h0, 2'h0, {5'h0, (m == 0), 4'h0, m[1], 2'b01, m[0]}, 1'b1, 1'b1, 1'b0);
            settle();
            check("mode", modeReg_r, {9'h0, m[1], 2'b01, m[0]});
            open(m[1:0]);
            c = 10'($random(seed));
            if (m == 3) c[2:0] = 3'h7;
            burst(1'b0, 1'b0, 1'b0, m[1:0], c, m[0], m[1], f0, n);
            check("rdBeats", n, m[0] ? 8 : 4);
            check("keepOpen", bankOpen_r[m[1:0]], 1);
            burst(1'b1, 1'b1, 1'b0, m[1:0], c ^ 10'h005, m[0], m[1], f2, n);
            check("wrBeats", n, m[0] ? 8 : 4);
            check("wrApClose", bankOpen_r[m[1:0]], 0);
        end
        ctl_u.issue(3'h0, 2'h1, 14'h0010, 1'b1, 1'b1, 1'b0);
        settle();
        check("ext", extModeReg_r, 13'h0010);
        ctl_u.issue(3'h0, 2'h2, 14'h1FFF, 1'b1, 1'b1, 1'b0);
        settle();
        check("loadBa2Mode", modeReg_r, 13'h000B);
        check("loadBa2Ext", extModeReg_r, 13'h0010);
        open(2'h2);
        burst(1'b0, 1'b1, 1'b0, 2'h2, 10'h3F2, 1'b1, 1'b1, f2, n);
        check("alDelay", f2 - f0, 2);
        check("rdApClose", bankOpen_r[2], 0);
        open(2'h1);
        burst(1'b1, 1'b0, 1'b1, 2'h1, 10'h011, 1'b1, 1'b1, f2, n);
        check("masked", n, 0);
        ctl_u.issue(3'h3, 2'h3, 14'h1234, 1'b0, 1'b1, 1'b0);
        settle();
        check("deselect", bankOpen_r[3], 0);
        open(2'h3);
        ctl_u.issue(3'h2, 2'h0, 14'h0400, 1'b1, 1'b1, 1'b0);
        settle();
        check("preAll", bankOpen_r, 0);
        ctl_u.issue(3'h2, 2'h0, 14'h0000, 1'b1, 1'b1, 1'b0);
        repeat (2) @(posedge clk_sys);
        ctl_u.issue(3'h2, 2'h0, 14'h0000, 1'b1, 1'b1, 1'b0);
        repeat (5) @(posedge clk_sys);
        #1;
        check("preRestart", bankPrecharging_r[0], 1);
        repeat (10) @(posedge clk_sys);
        #1;
        check("preDone", bankPrecharging_r, 0);
        for (int k = 0; k < 2; k++) begin
            r = refreshRow_r;
            ctl_u.issue(3'h1, 2'($random(seed)), 14'($random(seed)), 1'b1, 1'b1, 1'b0);
            #1;
            check("refStb", refreshStb_r, 1);
            settle();
            check("refRow", refreshRow_r, r + 14'h0001);
        end
        ctl_u.issue(3'h1, 2'h0, 14'h0000, 1'b1, 1'b0, 1'b0);
        #1;
        check("srStb", refreshStb_r, 1);
        settle();
        check("selfIn", selfRefresh_r, 1);
        check("dllOff", dllOn_r, 0);
        ctl_u.issue(3'h7, 2'h0, 14'h0000, 1'b1, 1'b1, 1'b0);
        #1;
        check("dllRst", dllReset_r, 1);
        settle();
        check("selfOut", selfRefresh_r, 0);
        check("dllBack", dllOn_r, 1);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
